// ===== inc/iicpc_defs.svh
// register map, field positions, reset values and timing figures of the protocol config core
`ifndef IICPC_DEFS_SVH
`define IICPC_DEFS_SVH

`define IICPC_AXI_AW        12
`define IICPC_BYTE(idx)     ((idx) << 2)

`define IICPC_IDX_OWN_ADDR  12'h040
`define IICPC_IDX_CTRL_HI   12'h042
`define IICPC_IDX_FLAGS     12'h044
`define IICPC_IDX_FLAG_CLR  12'h046
`define IICPC_IDX_IRQ_STAT  12'h048
`define IICPC_IDX_IRQ_MASK  12'h04a
`define IICPC_IDX_BUS_STAT  12'h04c

`define IICPC_RST_OWN_ADDR  16'h0000
`define IICPC_RST_CTRL_HI   16'h0000
`define IICPC_RST_IRQ_MASK  16'h0000
`define IICPC_CTRL_WMASK    16'hbfff
`define IICPC_FLAG_MASK     16'h01ff
`define IICPC_IRQ_EN_MASK   16'h01fc

`define IICPC_B_GENERAL_CALL_ACK_EN       0
`define IICPC_B_SYMBOL_TIMING_SELECT        1
`define IICPC_B_ADDRESSED   0
`define IICPC_B_WRONG_FMT   1
`define IICPC_B_START       2
`define IICPC_B_RESTART     3
`define IICPC_B_STOP        4
`define IICPC_B_NACK        5
`define IICPC_B_ARB_LOST    6
`define IICPC_B_SLAVE_READ  7
`define IICPC_B_ERROR       8

`define IICPC_A7_HI         15
`define IICPC_A7_LO         9
`define IICPC_PFX_HI        15
`define IICPC_PFX_LO        11
`define IICPC_TEN_PFX       5'h1e
`define IICPC_A2_HI         7
`define IICPC_A2_LO         0
`define IICPC_LAST_BIT      4'h7
`define IICPC_ACK_BIT       4'h8

`define IICPC_CLK_KHZ       200000
`define IICPC_STD_KHZ       100
`define IICPC_FAST_KHZ      400
`define IICPC_TQ_STD        10
`define IICPC_TQ_FAST       25
`define IICPC_TQW           8
`define IICPC_SYMW          5

`define IICPC_RESP_OKAY     2'h0
`define IICPC_RESP_SLVERR   2'h2

`endif

// ===== inc/iicpc_pkg.sv
// types shared by the protocol config core
`include "iicpc_defs.svh"
package iicpc_pkg;
	typedef enum logic [3:0] {
		IICPC_IDLE  = 4'h1,
		IICPC_ADDR1 = 4'h2,
		IICPC_ADDR2 = 4'h4,
		IICPC_DATA  = 4'h8
	} iicpc_state_t;

	typedef struct packed {
		logic                     awvalid;
		logic [`IICPC_AXI_AW-1:0] awaddr;
		logic                     wvalid;
		logic [31:0]              wdata;
		logic [3:0]               wstrb;
		logic                     bready;
		logic                     arvalid;
		logic [`IICPC_AXI_AW-1:0] araddr;
		logic                     rready;
	} iicpc_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} iicpc_axi_rsp_t;

	typedef struct packed {
		logic nack;
		logic arb_lost;
		logic bus_err;
		logic wrong_fmt;
	} iicpc_evt_t;

	typedef struct packed {
		iicpc_axi_rsp_t           rsp;
		logic                     aw_got;
		logic [`IICPC_AXI_AW-1:0] aw_addr;
		logic                     w_got;
		logic [31:0]              w_data;
		logic [3:0]               w_strb;
		logic [15:0]              own_addr;
		logic [15:0]              ctrl;
		logic [15:0]              irq_mask;
		iicpc_state_t             mode;
		logic [3:0]               bit_cnt;
		logic [7:0]               shreg;
		logic                     busy;
		logic                     addressed;
		logic                     slave_read;
		logic                     ten_hit;
		logic                     scl_d;
		logic                     sda_d;
		logic [`IICPC_TQW-1:0]    tq_cnt;
		logic [`IICPC_SYMW-1:0]   sym_cnt;
		logic [`IICPC_SYMW-1:0]   quanta;
		logic                     tq_tick;
		logic                     sym_tick;
		logic                     proto_irq;
		logic                     irq;
	} iicpc_core_t;
endpackage

// ===== rtl/iicpc_sync.sv
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module iicpc_sync #(
	parameter int             W    = 1,
	parameter logic [W-1:0]   INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} iicpc_sync_t;

	iicpc_sync_t st_reg;
	iicpc_sync_t st_next;

	// first stage feeds only the second
	always_comb begin
		st_next    = st_reg;
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_reg <= {INIT, INIT};
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.s2;
endmodule // iicpc_sync
`default_nettype wire

// ===== rtl/iicpc_flagbank.sv
// sticky flag bank: hardware and software set, clear by strobe, set beats clear
`timescale 1ns/1ps
`default_nettype none
module iicpc_flagbank #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] hw_set,
	input  wire logic [W-1:0] sw_set,
	input  wire logic [W-1:0] clr,
	output logic      [W-1:0] flags
);
	typedef struct packed {
		logic [W-1:0] flags;
	} iicpc_fb_t;

	iicpc_fb_t st_reg;
	iicpc_fb_t st_next;

	// an event in the clearing cycle survives
	always_comb begin
		st_next       = st_reg;
		st_next.flags = (st_reg.flags & ~clr) | sw_set | hw_set;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign flags = st_reg.flags;
endmodule // iicpc_flagbank
`default_nettype wire

// ===== rtl/iicpc_top.sv
// protocol configuration core: own address match, symbol timing, event flags, axi4-lite registers
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "iicpc_defs.svh"

module iicpc_top
	import iicpc_pkg::*;
#(
	parameter int CLK_KHZ = `IICPC_CLK_KHZ
) (
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire iicpc_axi_req_t         axi_req,
	output var  iicpc_axi_rsp_t         axi_rsp,
	input  wire logic                   scl_pin,
	input  wire logic                   sda_pin,
	input  wire iicpc_evt_t             evt,
	output logic                        irq,
	output logic                        proto_irq,
	output logic                        addr_match,
	output logic                        slave_read,
	output logic                        symbol_tick,
	output logic [`IICPC_SYMW-1:0]      symbol_quanta,
	output logic                        symbol_timing_select,
	output logic                        general_call_ack_en
);
	localparam logic [`IICPC_TQW-1:0] DIV_STD =
		`IICPC_TQW'(CLK_KHZ / (`IICPC_STD_KHZ * `IICPC_TQ_STD));
	localparam logic [`IICPC_TQW-1:0] DIV_FAST =
		`IICPC_TQW'(CLK_KHZ / (`IICPC_FAST_KHZ * `IICPC_TQ_FAST));
	localparam logic [`IICPC_SYMW-1:0] Q_STD  = `IICPC_SYMW'(`IICPC_TQ_STD);
	localparam logic [`IICPC_SYMW-1:0] Q_FAST = `IICPC_SYMW'(`IICPC_TQ_FAST);

	iicpc_core_t             st_reg;
	iicpc_core_t             st_next;
	logic                    scl_s;
	logic                    sda_s;
	logic                    scl_rise;
	logic                    start_c;
	logic                    stop_c;
	logic                    byte_done;
	logic [7:0]              byte_w;
	logic [15:0]             hw_set;
	logic [15:0]             sw_set;
	logic [15:0]             flag_clr;
	logic [15:0]             irq_set;
	logic [15:0]             irq_rdclr;
	logic [15:0]             flags;
	logic [15:0]             irq_stat;
	logic [15:0]             wmask;
	logic [15:0]             wr_val;
	logic [`IICPC_TQW-1:0]   tq_div;
	logic [`IICPC_SYMW-1:0]  quanta_n;

	// the link clock is only sampled, never used as a clock
	iicpc_sync #(
		.W    (2),
		.INIT (2'h3)
	) u_pin_sync (
		.clk  (clk),
		.nrst (nrst),
		.d    ({scl_pin, sda_pin}),
		.q    ({scl_s, sda_s})
	);

	iicpc_flagbank #(
		.W (16)
	) u_flags (
		.clk    (clk),
		.nrst   (nrst),
		.hw_set (hw_set),
		.sw_set (sw_set),
		.clr    (flag_clr),
		.flags  (flags)
	);

	iicpc_flagbank #(
		.W (16)
	) u_irq_stat (
		.clk    (clk),
		.nrst   (nrst),
		.hw_set (irq_set),
		.sw_set (16'h0000),
		.clr    (irq_rdclr),
		.flags  (irq_stat)
	);

	always_comb begin
		st_next          = st_reg;
		hw_set           = '0;
		sw_set           = '0;
		flag_clr         = '0;
		irq_rdclr        = '0;
		scl_rise         = scl_s & ~st_reg.scl_d;
		start_c          = st_reg.scl_d & scl_s & st_reg.sda_d & ~sda_s;
		stop_c           = st_reg.scl_d & scl_s & ~st_reg.sda_d & sda_s;
		byte_w           = {st_reg.shreg[6:0], sda_s};
		byte_done        = scl_rise && (st_reg.bit_cnt == `IICPC_LAST_BIT);
		st_next.scl_d    = scl_s;
		st_next.sda_d    = sda_s;
		st_next.tq_tick  = 1'b0;
		st_next.sym_tick = 1'b0;
		quanta_n = st_reg.ctrl[`IICPC_B_SYMBOL_TIMING_SELECT] ? Q_FAST : Q_STD;
		tq_div   = st_reg.ctrl[`IICPC_B_SYMBOL_TIMING_SELECT] ? DIV_FAST : DIV_STD;
		st_next.quanta = quanta_n;

		// >= keeps the counters sane if the selector flips mid-symbol
		if (st_reg.tq_cnt >= tq_div - `IICPC_TQW'(1)) begin
			st_next.tq_cnt  = '0;
			st_next.tq_tick = 1'b1;
			if (st_reg.sym_cnt >= quanta_n - `IICPC_SYMW'(1)) begin
				st_next.sym_cnt  = '0;
				st_next.sym_tick = 1'b1;
			end else begin
				st_next.sym_cnt = st_reg.sym_cnt + `IICPC_SYMW'(1);
			end
		end else begin
			st_next.tq_cnt = st_reg.tq_cnt + `IICPC_TQW'(1);
		end

		if (start_c) begin
			if (st_reg.busy) begin
				hw_set[`IICPC_B_RESTART] = 1'b1;
			end else begin
				hw_set[`IICPC_B_START] = 1'b1;
			end
			st_next.busy       = 1'b1;
			st_next.mode       = IICPC_ADDR1;
			st_next.bit_cnt    = '0;
			st_next.addressed  = 1'b0;
			st_next.slave_read = 1'b0;
			st_next.tq_cnt     = '0;
			st_next.sym_cnt    = '0;
		end else if (stop_c) begin
			hw_set[`IICPC_B_STOP] = 1'b1;
			st_next.busy       = 1'b0;
			st_next.mode       = IICPC_IDLE;
			st_next.addressed  = 1'b0;
			st_next.slave_read = 1'b0;
			st_next.ten_hit    = 1'b0;
		end else if (scl_rise && st_reg.mode != IICPC_IDLE) begin
			st_next.shreg   = byte_w;
			st_next.bit_cnt = (st_reg.bit_cnt == `IICPC_ACK_BIT) ? 4'h0 : st_reg.bit_cnt + 4'h1;
			if (byte_done) begin
				unique case (st_reg.mode)
				IICPC_ADDR1: begin
					if (byte_w[7:1] == st_reg.own_addr[`IICPC_A7_HI:`IICPC_A7_LO]) begin
						if (st_reg.own_addr[`IICPC_PFX_HI:`IICPC_PFX_LO] == `IICPC_TEN_PFX) begin
							if (byte_w[0] && st_reg.ten_hit) begin
								// ten-bit read after a restart reuses the earlier full match
								st_next.addressed  = 1'b1;
								st_next.slave_read = 1'b1;
								hw_set[`IICPC_B_ADDRESSED]  = 1'b1;
								hw_set[`IICPC_B_SLAVE_READ] = 1'b1;
								st_next.mode = IICPC_DATA;
							end else if (byte_w[0]) begin
								st_next.mode = IICPC_DATA;
							end else begin
								st_next.mode = IICPC_ADDR2;
							end
						end else begin
							st_next.addressed  = 1'b1;
							st_next.slave_read = byte_w[0];
							hw_set[`IICPC_B_ADDRESSED]  = 1'b1;
							hw_set[`IICPC_B_SLAVE_READ] = byte_w[0];
							st_next.mode = IICPC_DATA;
						end
					end else begin
						st_next.ten_hit = 1'b0;
						st_next.mode    = IICPC_DATA;
					end
				end
				IICPC_ADDR2: begin
					if (byte_w == st_reg.own_addr[`IICPC_A2_HI:`IICPC_A2_LO]) begin
						st_next.addressed = 1'b1;
						st_next.ten_hit   = 1'b1;
						hw_set[`IICPC_B_ADDRESSED] = 1'b1;
					end
					st_next.mode = IICPC_DATA;
				end
				IICPC_IDLE, IICPC_DATA: begin
				end
				endcase
			end
		end

		hw_set[`IICPC_B_NACK]      = evt.nack;
		hw_set[`IICPC_B_ARB_LOST]  = evt.arb_lost;
		hw_set[`IICPC_B_WRONG_FMT] = evt.wrong_fmt;
		hw_set[`IICPC_B_ERROR]     = evt.bus_err | evt.wrong_fmt;
		// enables in ctrl share the event bit positions
		irq_set = hw_set & st_reg.ctrl & `IICPC_IRQ_EN_MASK;
		st_next.proto_irq = |irq_set;
		st_next.irq = |(irq_stat & st_reg.irq_mask);

		if (st_reg.rsp.awready && axi_req.awvalid) begin
			st_next.aw_got  = 1'b1;
			st_next.aw_addr = axi_req.awaddr;
		end
		if (st_reg.rsp.wready && axi_req.wvalid) begin
			st_next.w_got  = 1'b1;
			st_next.w_data = axi_req.wdata;
			st_next.w_strb = axi_req.wstrb;
		end
		if (st_reg.rsp.bvalid && axi_req.bready) begin
			st_next.rsp.bvalid = 1'b0;
		end
		wmask  = {{8{st_reg.w_strb[1]}}, {8{st_reg.w_strb[0]}}};
		wr_val = st_reg.w_data[15:0] & wmask;
		if (st_reg.aw_got && st_reg.w_got && !st_reg.rsp.bvalid) begin
			st_next.aw_got     = 1'b0;
			st_next.w_got      = 1'b0;
			st_next.rsp.bvalid = 1'b1;
			st_next.rsp.bresp  = `IICPC_RESP_OKAY;
			unique case (st_reg.aw_addr)
			`IICPC_BYTE(`IICPC_IDX_OWN_ADDR): st_next.own_addr = (st_reg.own_addr & ~wmask) | wr_val;
			`IICPC_BYTE(`IICPC_IDX_CTRL_HI):
				st_next.ctrl = ((st_reg.ctrl & ~wmask) | wr_val) & `IICPC_CTRL_WMASK;
			`IICPC_BYTE(`IICPC_IDX_FLAGS):    sw_set   = wr_val & `IICPC_FLAG_MASK;
			`IICPC_BYTE(`IICPC_IDX_FLAG_CLR): flag_clr = wr_val & `IICPC_FLAG_MASK;
			`IICPC_BYTE(`IICPC_IDX_IRQ_MASK):
				st_next.irq_mask = ((st_reg.irq_mask & ~wmask) | wr_val) & `IICPC_IRQ_EN_MASK;
			`IICPC_BYTE(`IICPC_IDX_IRQ_STAT), `IICPC_BYTE(`IICPC_IDX_BUS_STAT): begin
			end
			default: st_next.rsp.bresp = `IICPC_RESP_SLVERR;
			endcase
		end

		if (st_reg.rsp.rvalid && axi_req.rready) begin
			st_next.rsp.rvalid = 1'b0;
		end
		if (st_reg.rsp.arready && axi_req.arvalid) begin
			st_next.rsp.rvalid = 1'b1;
			st_next.rsp.rresp  = `IICPC_RESP_OKAY;
			st_next.rsp.rdata  = '0;
			unique case (axi_req.araddr)
			`IICPC_BYTE(`IICPC_IDX_OWN_ADDR): st_next.rsp.rdata = 32'(st_reg.own_addr);
			`IICPC_BYTE(`IICPC_IDX_CTRL_HI):  st_next.rsp.rdata = 32'(st_reg.ctrl);
			`IICPC_BYTE(`IICPC_IDX_FLAGS):    st_next.rsp.rdata = 32'(flags);
			`IICPC_BYTE(`IICPC_IDX_FLAG_CLR): begin
			end
			`IICPC_BYTE(`IICPC_IDX_IRQ_STAT): begin
				st_next.rsp.rdata = 32'(irq_stat);
				irq_rdclr = irq_stat;
			end
			`IICPC_BYTE(`IICPC_IDX_IRQ_MASK): st_next.rsp.rdata = 32'(st_reg.irq_mask);
			`IICPC_BYTE(`IICPC_IDX_BUS_STAT):
				st_next.rsp.rdata = 32'({st_reg.quanta, st_reg.ten_hit, st_reg.slave_read,
					st_reg.addressed, st_reg.busy});
			default: st_next.rsp.rresp = `IICPC_RESP_SLVERR;
			endcase
		end
		st_next.rsp.awready = !st_next.aw_got && !st_next.rsp.bvalid;
		st_next.rsp.wready  = !st_next.w_got && !st_next.rsp.bvalid;
		st_next.rsp.arready = !st_next.rsp.rvalid;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_reg          <= '0;
			st_reg.own_addr <= `IICPC_RST_OWN_ADDR;
			st_reg.ctrl     <= `IICPC_RST_CTRL_HI;
			st_reg.irq_mask <= `IICPC_RST_IRQ_MASK;
			st_reg.mode     <= IICPC_IDLE;
			st_reg.scl_d    <= 1'b1;
			st_reg.sda_d    <= 1'b1;
			st_reg.quanta   <= Q_STD;
		end else begin
			st_reg <= st_next;
		end
	end

	assign axi_rsp              = st_reg.rsp;
	assign irq                  = st_reg.irq;
	assign proto_irq            = st_reg.proto_irq;
	assign addr_match           = st_reg.addressed;
	assign slave_read           = st_reg.slave_read;
	assign symbol_tick          = st_reg.sym_tick;
	assign symbol_quanta        = st_reg.quanta;
	assign symbol_timing_select = st_reg.ctrl[`IICPC_B_SYMBOL_TIMING_SELECT];
	assign general_call_ack_en  = st_reg.ctrl[`IICPC_B_GENERAL_CALL_ACK_EN];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_match7;
		byte_done && !start_c && !stop_c && st_reg.mode == IICPC_ADDR1 &&
		byte_w[7:1] == st_reg.own_addr[`IICPC_A7_HI:`IICPC_A7_LO] &&
		st_reg.own_addr[`IICPC_PFX_HI:`IICPC_PFX_LO] != `IICPC_TEN_PFX
		|=> addr_match && slave_read == $past(sda_s) ##1 flags[`IICPC_B_ADDRESSED];
	endproperty
	a_match7: assert property (p_match7) else $error("seven-bit match not taken");

	property p_ten_second;
		byte_done && !start_c && !stop_c && st_reg.mode == IICPC_ADDR1 && !sda_s &&
		byte_w[7:1] == st_reg.own_addr[`IICPC_A7_HI:`IICPC_A7_LO] &&
		st_reg.own_addr[`IICPC_PFX_HI:`IICPC_PFX_LO] == `IICPC_TEN_PFX
		|=> st_reg.mode == IICPC_ADDR2 && !addr_match;
	endproperty
	a_ten_second: assert property (p_ten_second) else $error("ten-bit prefix did not wait");

	property p_sym_std;
		st_reg.tq_tick && !start_c && !symbol_timing_select && $stable(symbol_timing_select) &&
		st_reg.sym_cnt == 5'd0 ##0 $past(st_reg.sym_cnt) == 5'd9 |-> symbol_tick;
	endproperty
	a_sym_std: assert property (p_sym_std) else $error("standard symbol not ten quanta");

	property p_sym_fast;
		symbol_tick && symbol_timing_select && $past(symbol_timing_select, 2)
		|-> $past(st_reg.sym_cnt) == 5'd24;
	endproperty
	a_sym_fast: assert property (p_sym_fast) else $error("fast symbol not 25 quanta");

	property p_start_irq;
		start_c && !st_reg.busy && st_reg.ctrl[`IICPC_B_START] |=> irq_stat[`IICPC_B_START] && proto_irq;
	endproperty
	a_start_irq: assert property (p_start_irq) else $error("start interrupt missing");

	property p_restart_off;
		start_c && st_reg.busy && !st_reg.ctrl[`IICPC_B_RESTART] && !irq_stat[`IICPC_B_RESTART]
		|=> !irq_stat[`IICPC_B_RESTART];
	endproperty
	a_restart_off: assert property (p_restart_off) else $error("disabled restart raised irq");

	property p_stop_irq;
		stop_c && st_reg.ctrl[`IICPC_B_STOP] && st_reg.irq_mask[`IICPC_B_STOP] |=> ##1 irq;
	endproperty
	a_stop_irq: assert property (p_stop_irq) else $error("stop did not reach irq");

	property p_nack_irq;
		evt.nack && st_reg.ctrl[`IICPC_B_NACK] |=> irq_stat[`IICPC_B_NACK];
	endproperty
	a_nack_irq: assert property (p_nack_irq) else $error("no-ack interrupt missing");

	property p_arb_irq;
		evt.arb_lost && st_reg.ctrl[`IICPC_B_ARB_LOST] |=> irq_stat[`IICPC_B_ARB_LOST];
	endproperty
	a_arb_irq: assert property (p_arb_irq) else $error("arbitration interrupt missing");

	property p_err_irq;
		evt.wrong_fmt && st_reg.ctrl[`IICPC_B_ERROR]
		|=> irq_stat[`IICPC_B_ERROR] && flags[`IICPC_B_WRONG_FMT];
	endproperty
	a_err_irq: assert property (p_err_irq) else $error("format error interrupt missing");

	property p_sw_set_quiet;
		(|sw_set) && irq_set == 16'h0000 && irq_stat == 16'h0000 |=> irq_stat == 16'h0000;
	endproperty
	a_sw_set_quiet: assert property (p_sw_set_quiet) else $error("software set raised irq");

	property p_srr_flag;
		hw_set[`IICPC_B_SLAVE_READ] && st_reg.ctrl[`IICPC_B_SLAVE_READ]
		|=> irq_stat[`IICPC_B_SLAVE_READ] && slave_read && addr_match;
	endproperty
	a_srr_flag: assert property (p_srr_flag) else $error("slave read request not flagged");

	c_start:   cover property (start_c && !st_reg.busy);
	c_matched: cover property ($rose(addr_match));
	c_ten:     cover property (st_reg.mode == IICPC_ADDR2 ##[1:400] addr_match);
	c_irq:     cover property ($rose(irq));
endmodule // iicpc_top
`default_nettype wire

// ===== bench/iicpc_bus_model.sv
// behavioural far-side master that drives the two-wire bus pins
`timescale 1ns/1ps
`default_nettype none
module iicpc_bus_model (
	output var logic scl,
	output var logic sda
);
	localparam realtime Q = 31.25;
	// open-drain lines with pull-ups: idle and released levels read high
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// also serves as repeated start; the odd offset breaks phase lock with the core clock
	task automatic start();
		#1.7;
		sda = 1'b1;
		#Q scl = 1'b1;
		#Q sda = 1'b0;
		#Q scl = 1'b0;
		#Q;
	endtask
	// msb first, ninth slot released so nobody acknowledges
	task automatic send(input logic [7:0] b);
		for (int i = 8; i >= 0; i--) begin
			sda = (i == 0) ? 1'b1 : b[i - 1];
			#Q scl = 1'b1;
			#(2 * Q) scl = 1'b0;
			#Q;
		end
	endtask
	task automatic stop();
		sda = 1'b0;
		#Q scl = 1'b1;
		#Q sda = 1'b1;
		#Q;
	endtask
endmodule // iicpc_bus_model
`default_nettype wire

// ===== bench/iicpc_tb.sv
// self-checking bench of the protocol config core
`timescale 1ns/1ps
`default_nettype none
`include "iicpc_defs.svh"
module tb;
	import iicpc_pkg::*;
	localparam int KHZ = 20000;
	localparam logic [11:0] A_OWN = `IICPC_BYTE(`IICPC_IDX_OWN_ADDR);
	localparam logic [11:0] A_CTL = `IICPC_BYTE(`IICPC_IDX_CTRL_HI);
	localparam logic [11:0] A_FLG = `IICPC_BYTE(`IICPC_IDX_FLAGS);
	localparam logic [11:0] A_CLR = `IICPC_BYTE(`IICPC_IDX_FLAG_CLR);
	localparam logic [11:0] A_IST = `IICPC_BYTE(`IICPC_IDX_IRQ_STAT);
	localparam logic [11:0] A_MSK = `IICPC_BYTE(`IICPC_IDX_IRQ_MASK);
	logic clk, nrst, scl, sda, irq, proto_irq, addr_match, slave_read, tick, sts, gca;
	iicpc_axi_req_t req;
	iicpc_axi_rsp_t rsp;
	iicpc_evt_t     evt;
	logic [4:0]     quanta;
	logic [31:0]    rd;
	logic [1:0]     rr;
	int             failures, compares, pulses, p;
	// small divider keeps a symbol at 200 and 50 cycles
	iicpc_top #(.CLK_KHZ(KHZ)) u_dut (.clk(clk), .nrst(nrst), .axi_req(req), .axi_rsp(rsp),
		.scl_pin(scl), .sda_pin(sda), .evt(evt), .irq(irq), .proto_irq(proto_irq),
		.addr_match(addr_match), .slave_read(slave_read), .symbol_tick(tick),
		.symbol_quanta(quanta), .symbol_timing_select(sts), .general_call_ack_en(gca));
	iicpc_bus_model u_bus (.scl(scl), .sda(sda));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) if (proto_irq === 1'b1) pulses <= pulses + 1;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic hang();
		failures++;
		give_verdict();
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// each channel released at the edge that takes it; bready held until bvalid
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
		logic aw, w, b;
		aw = 0;
		w = 0;
		b = 0;
		@(posedge clk);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= s;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		for (int n = 0; n < 100 && !b; n++) begin
			@(posedge clk);
			if (!aw && rsp.awready === 1'b1) begin
				aw = 1;
				req.awvalid <= 1'b0;
			end
			if (!w && rsp.wready === 1'b1) begin
				w = 1;
				req.wvalid <= 1'b0;
			end
			if (rsp.bvalid === 1'b1) begin
				b = 1;
				rr = rsp.bresp;
				req.bready <= 1'b0;
			end
		end
		if (!b) hang();
	endtask
	task automatic rdr(input logic [11:0] a);
		logic got;
		got = 0;
		@(posedge clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		for (int n = 0; n < 100 && !got; n++) begin
			@(posedge clk);
			if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
			if (rsp.rvalid === 1'b1) begin
				got = 1;
				rd = rsp.rdata;
				rr = rsp.rresp;
				req.rready <= 1'b0;
			end
		end
		if (!got) hang();
	endtask
	task automatic fire(input logic [3:0] v);
		@(posedge clk);
		evt <= iicpc_evt_t'(v);
		@(posedge clk);
		evt <= '0;
	endtask
	task automatic gap(output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (tick !== 1'b1 && n < 1000);
		if (n >= 1000) hang();
	endtask
	task automatic t_regs();
		rdr(A_OWN);
		chk(rd, 32'h0);
		rdr(A_CTL);
		chk(rd, 32'h0);
		wr(A_OWN, 32'hffff_1234);
		rdr(A_OWN);
		chk(rd, 32'h0000_1234);
		// only the high byte lane is enabled here
		wr(A_OWN, 32'h5555_ab99, 4'h2);
		rdr(A_OWN);
		chk(rd, 32'h0000_ab34);
		wr(A_CTL, 32'hffff);
		rdr(A_CTL);
		chk(rd, {16'h0, `IICPC_CTRL_WMASK});
		chk({sts, gca}, 2'h3);
		rdr(12'h3fc);
		chk({30'h0, rr}, {30'h0, `IICPC_RESP_SLVERR});
		wr(12'h3fc, 32'h0);
		chk({30'h0, rr}, {30'h0, `IICPC_RESP_SLVERR});
		wr(A_CTL, 32'h0);
		chk({sts, gca}, 2'h0);
		$display("test regs done");
	endtask
	task automatic t_timing();
		int n;
		for (int k = 0; k < 2; k++) begin
			wr(A_CTL, 32'(k << 1));
			gap(n);
			gap(n);
			gap(n);
			chk(n, k ? KHZ / `IICPC_FAST_KHZ : KHZ / `IICPC_STD_KHZ);
			chk(quanta, k ? `IICPC_TQ_FAST : `IICPC_TQ_STD);
			chk(sts, k);
		end
		$display("test timing done");
	endtask
	task automatic t_events();
		int b;
		wr(A_MSK, 32'h1fc);
		for (int k = 0; k < 4; k++) begin
			b = (k < 2) ? 5 + k : 8;
			wr(A_CTL, 32'h0);
			p = pulses;
			fire(4'h8 >> k);
			cyc(4);
			chk(pulses - p, 0);
			chk(irq, 0);
			wr(A_CTL, 32'h1 << b);
			p = pulses;
			fire(4'h8 >> k);
			cyc(4);
			chk(pulses - p, 1);
			chk(irq, 1);
			rdr(A_IST);
			chk(rd[b], 1);
			rdr(A_FLG);
			chk(rd[b], 1);
			wr(A_CLR, 32'h1ff);
			rdr(A_FLG);
			chk(rd, 0);
			chk(irq, 0);
		end
		$display("test events done");
	endtask
	task automatic t_soft();
		wr(A_CTL, 32'h1fc);
		p = pulses;
		wr(A_FLG, 32'h20);
		cyc(60);
		chk(pulses - p, 0);
		chk(irq, 0);
		rdr(A_FLG);
		chk(rd, 32'h20);
		wr(A_CLR, 32'h20);
		rdr(A_FLG);
		chk(rd, 0);
		$display("test soft flags done");
	endtask
	task automatic t_addr7();
		wr(A_OWN, 32'hb400);
		wr(A_CTL, 32'h94);
		p = pulses;
		u_bus.start();
		cyc(6);
		chk(pulses - p, 1);
		u_bus.send(8'hb5);
		cyc(6);
		chk(addr_match, 1);
		chk(slave_read, 1);
		chk(pulses - p, 2);
		u_bus.stop();
		cyc(6);
		chk(pulses - p, 3);
		chk(addr_match, 0);
		rdr(A_FLG);
		chk(rd & 32'h94, 32'h94);
		wr(A_CLR, 32'h1ff);
		wr(A_CTL, 32'h0);
		p = pulses;
		u_bus.start();
		u_bus.send(8'hb7);
		cyc(6);
		chk(addr_match, 0);
		u_bus.stop();
		cyc(6);
		chk(pulses - p, 0);
		$display("test seven-bit address done");
	endtask
	task automatic t_addr10();
		wr(A_OWN, 32'hf2a5);
		wr(A_CTL, 32'h8);
		p = pulses;
		u_bus.start();
		u_bus.send(8'hf2);
		cyc(6);
		chk(addr_match, 0);
		u_bus.send(8'ha5);
		cyc(6);
		chk(addr_match, 1);
		chk(slave_read, 0);
		u_bus.start();
		u_bus.send(8'hf3);
		cyc(6);
		chk(pulses - p, 1);
		chk(slave_read, 1);
		// busy, addressed, read, ten-bit hit and ten quanta while the bus is held
		rdr(`IICPC_BYTE(`IICPC_IDX_BUS_STAT));
		chk(rd, 32'h0000_00af);
		u_bus.stop();
		u_bus.start();
		u_bus.send(8'hf2);
		u_bus.send(8'ha4);
		cyc(6);
		chk(addr_match, 0);
		u_bus.stop();
		cyc(6);
		chk(pulses - p, 1);
		$display("test ten-bit address done");
	endtask
	initial begin
		req = '0;
		evt = '0;
		nrst = 1'b0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		cyc(2);
		t_regs();
		t_timing();
		t_events();
		t_soft();
		t_addr7();
		t_addr10();
		give_verdict();
	end
endmodule // tb
`default_nettype wire
